/* src/phase_pipe_params.svh */
// Constants for the instruction phase pipeline: fields, reset values, timing
`ifndef PHASE_PIPE_PARAMS_SVH
`define PHASE_PIPE_PARAMS_SVH
`define IW 14
`define OP_MSB 13
`define OP_LSB 10
`define ARG_MSB 9
`define IMM_MSB 7
`define PC_LOW_MSB 7
`define PC_RESET 10'h000
`define ACC_RESET 8'h00
`define STARTUP_TSYS 1024
`define TSYS_NS 8
`define CLK_NS 8
`define STARTUP_CYCLES ((`STARTUP_TSYS * `TSYS_NS) / `CLK_NS)
`endif

/* src/phase_pipe_pkg.sv */
// Types shared by the instruction phase pipeline
package phase_pipe_pkg;
    typedef enum logic [1:0] {
        PH_FETCH  = 2'h0,
        PH_DECODE = 2'h1,
        PH_EXEC   = 2'h3,
        PH_WRITE  = 2'h2
    } phase_e;
    typedef enum logic [1:0] {
        PW_RUN   = 2'h0,
        PW_SLEEP = 2'h1,
        PW_START = 2'h3
    } power_e;
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_LDI = 4'h1, OP_MOVA = 4'h2, OP_MOVM = 4'h3,
        OP_ADD = 4'h4, OP_SUB = 4'h5, OP_AND = 4'h6, OP_OR = 4'h7,
        OP_XOR = 4'h8, OP_INC = 4'h9, OP_DEC = 4'hA, OP_RL = 4'hB,
        OP_RR = 4'hC, OP_SZ = 4'hD, OP_JMP = 4'hE, OP_SYS = 4'hF
    } op_e;
    typedef struct packed {
        logic fetch_phase;
        logic [2:0] decode_execute_phases;
    } phase_flags_s;
endpackage

/* src/data_ram.sv */
// Small operand memory with registered read data
`timescale 1ns/1ps
module data_ram #(
    parameter int DW = 8,
    parameter int AW = 6
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Access port
    input  wire logic [AW-1:0] addr_i,
    input  wire logic we_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] rdata_q;

    // Array carries no reset, so contents are undefined until written
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[addr_i] <= wdata_i;
        end
    end

    // Read port registered; a write shows on the next read, not the same edge
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem_q[addr_i];
        end
    end

    assign rdata_o = rdata_q;
endmodule

/* src/instruction_phase_pipeline.sv */
// Four-phase fetch/execute pipeline of a small 8-bit core
`timescale 1ns/1ps
`include "phase_pipe_params.svh"

// Summary of operation
// - Four non-overlapping phases in fixed order
// - PC advances and fetch happens in fetch_phase
// - Later three phases decode and execute previous
// - One phase sequence is one instruction cycle
// - Fetch overlaps execute, one per cycle
// - PC-changing instructions take two cycles
// - RC option drives fetch clock on pin
// - Pin high one clock, low three
// - Wake-up waits 1024 clocks before resuming
// - 8-bit ALU operations through the accumulator
// - Taken skip discards prefetch, dummy cycle
// - pc_low_byte write branches in page, dummy
module instruction_phase_pipeline
    import phase_pipe_pkg::*;
#(
    parameter int PC_W = 10,
    parameter int AW = 6,
    parameter int STARTUP_CYCLES = `STARTUP_CYCLES
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Program memory
    output logic [PC_W-1:0] prog_addr_o,
    input  wire logic [`IW-1:0] prog_data_i,
    // Pins
    input  wire logic rc_osc_sel_i,
    input  wire logic wake_i,
    output logic osc_out_pin_o,
    output logic osc_out_oe_o,
    // Status
    output phase_flags_s phase_flags_o,
    output logic [7:0] acc_o,
    output logic [PC_W-1:0] pc_o,
    output logic halted_o,
    output logic retire_o
);
    localparam int CW = $clog2(STARTUP_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] rc_sync_q, wake_sync_q;
    logic rc_s, wake_s;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rc_sync_q <= 2'h0;
            wake_sync_q <= 2'h0;
        end else begin
            rc_sync_q <= {rc_sync_q[0], rc_osc_sel_i};
            wake_sync_q <= {wake_sync_q[0], wake_i};
        end
    end
    assign rc_s = rc_sync_q[1];
    assign wake_s = wake_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // State
    phase_e phase_q, phase_d;
    power_e power_q, power_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [`IW-1:0] fetch_ir_q, fetch_ir_d, exec_ir_q, exec_ir_d;
    logic fetch_valid_q, fetch_valid_d, exec_valid_q, exec_valid_d;
    logic [7:0] acc_q, acc_d;
    logic osc_q, osc_d;
    logic retire_q, retire_d;

    op_e op;
    logic [7:0] rdata, alu_res;
    logic writes_acc, at_boundary, redirect, halt_now, ram_we;
    logic [PC_W-1:0] target;

    assign op = op_e'(exec_ir_q[`OP_MSB:`OP_LSB]);
    assign at_boundary = (power_q == PW_RUN) && (phase_q == PH_WRITE);

    // Operand read is addressed all cycle, so data is steady from PH_EXEC on
    data_ram #(.DW(8), .AW(AW)) data_ram_inst (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .addr_i(exec_ir_q[AW-1:0]),
        .we_i(ram_we),
        .wdata_i(acc_q),
        .rdata_o(rdata)
    );
    assign ram_we = exec_valid_q && (op == OP_MOVM) && (phase_q == PH_WRITE);

    ////////////////////////////////////////////////////////////////////////////
    // ALU and branch decisions
    always_comb begin
        alu_res = acc_q;
        writes_acc = 1'b1;
        case (op)
            OP_LDI: alu_res = exec_ir_q[`IMM_MSB:0];
            OP_MOVA: alu_res = rdata;
            OP_ADD: alu_res = 8'(acc_q + rdata);
            OP_SUB: alu_res = 8'(acc_q - rdata);
            OP_AND: alu_res = acc_q & rdata;
            OP_OR: alu_res = acc_q | rdata;
            OP_XOR: alu_res = acc_q ^ rdata;
            OP_INC: alu_res = 8'(rdata + 8'h01);
            OP_DEC: alu_res = 8'(rdata - 8'h01);
            OP_RL: alu_res = {rdata[6:0], rdata[7]};
            OP_RR: alu_res = {rdata[0], rdata[7:1]};
            default: writes_acc = 1'b0;
        endcase
    end

    always_comb begin
        redirect = 1'b0;
        halt_now = 1'b0;
        target = '0;
        if (exec_valid_q) begin
            case (op)
                OP_JMP: begin
                    redirect = 1'b1;
                    target = exec_ir_q[PC_W-1:0];
                end
                OP_SZ: begin
                    redirect = (rdata == 8'h00);
                    target = PC_W'(pc_q + 1'b1);
                end
                OP_SYS: begin
                    if (exec_ir_q[0]) begin
                        redirect = 1'b1;
                        target = {pc_q[PC_W-1:`PC_LOW_MSB+1], acc_q};
                    end else begin
                        halt_now = 1'b1;
                    end
                end
                default: redirect = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase sequencer, pipeline registers and power control
    always_comb begin
        phase_d = phase_q;
        power_d = power_q;
        cnt_d = cnt_q;
        pc_d = pc_q;
        fetch_ir_d = fetch_ir_q;
        fetch_valid_d = fetch_valid_q;
        exec_ir_d = exec_ir_q;
        exec_valid_d = exec_valid_q;
        acc_d = acc_q;
        retire_d = 1'b0;
        case (power_q)
            PW_RUN: begin
                case (phase_q)
                    PH_FETCH: begin
                        phase_d = PH_DECODE;
                        fetch_ir_d = prog_data_i;
                        fetch_valid_d = 1'b1;
                    end
                    PH_DECODE: phase_d = PH_EXEC;
                    PH_EXEC: phase_d = PH_WRITE;
                    PH_WRITE: begin
                        phase_d = PH_FETCH;
                        if (exec_valid_q && writes_acc) begin
                            acc_d = alu_res;
                        end
                        retire_d = exec_valid_q;
                        exec_ir_d = fetch_ir_q;
                        if (redirect) begin
                            pc_d = target;
                            exec_valid_d = 1'b0;
                        end else begin
                            pc_d = PC_W'(pc_q + 1'b1);
                            exec_valid_d = fetch_valid_q;
                        end
                        if (halt_now) begin
                            power_d = PW_SLEEP;
                        end
                    end
                    default: phase_d = PH_FETCH;
                endcase
            end
            PW_SLEEP: begin
                if (wake_s) begin
                    power_d = PW_START;
                    cnt_d = '0;
                end
            end
            PW_START: begin
                // Counter limited to the start-up wait; wake level is ignored here
                if (cnt_q == CW'(STARTUP_CYCLES - 1)) begin
                    power_d = PW_RUN;
                end else begin
                    cnt_d = CW'(cnt_q + 1'b1);
                end
            end
            default: power_d = PW_RUN;
        endcase
        // Pin pulses only in fetch_phase while running, giving a 1:3 duty
        osc_d = rc_s && (power_d == PW_RUN) && (phase_d == PH_FETCH);
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            phase_q <= PH_FETCH;
            power_q <= PW_RUN;
            cnt_q <= '0;
            pc_q <= `PC_RESET;
            fetch_ir_q <= '0;
            fetch_valid_q <= 1'b0;
            exec_ir_q <= '0;
            exec_valid_q <= 1'b0;
            acc_q <= `ACC_RESET;
            osc_q <= 1'b0;
            retire_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            power_q <= power_d;
            cnt_q <= cnt_d;
            pc_q <= pc_d;
            fetch_ir_q <= fetch_ir_d;
            fetch_valid_q <= fetch_valid_d;
            exec_ir_q <= exec_ir_d;
            exec_valid_q <= exec_valid_d;
            acc_q <= acc_d;
            osc_q <= osc_d;
            retire_q <= retire_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prog_addr_o = pc_q;
    assign pc_o = pc_q;
    assign acc_o = acc_q;
    assign osc_out_pin_o = osc_q;
    assign osc_out_oe_o = rc_s; // Pin left to the oscillator when crystal is chosen
    assign halted_o = (power_q != PW_RUN);
    assign retire_o = retire_q;
    assign phase_flags_o.fetch_phase = (phase_q == PH_FETCH);
    assign phase_flags_o.decode_execute_phases = {phase_q == PH_WRITE,
        phase_q == PH_EXEC, phase_q == PH_DECODE};

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // Helper: length of the current start-up wait
    logic [CW:0] start_len_q;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || power_q != PW_START) begin
            start_len_q <= '0;
        end else begin
            start_len_q <= (CW+1)'(start_len_q + 1'b1);
        end
    end

    a_phase_order: assert property (
        (phase_q == PH_FETCH && power_q == PW_RUN) |=>
        phase_q == PH_DECODE ##1 phase_q == PH_EXEC ##1 phase_q == PH_WRITE)
        else $error("phase order broken");
    a_pc_advance: assert property (
        (at_boundary && !redirect) |=> pc_q == PC_W'($past(pc_q) + 1'b1))
        else $error("pc not advanced at fetch");
    a_exec_phase: assert property (
        (!at_boundary) |=> (acc_q == $past(acc_q)))
        else $error("accumulator changed outside execute phase");
    a_cycle_four: assert property (
        (at_boundary && power_d == PW_RUN) |-> ##4 at_boundary)
        else $error("cycle not four clocks");
    a_retire_rate: assert property (
        (at_boundary && !redirect && fetch_valid_q && !halt_now) |-> ##5 retire_o)
        else $error("sequential instruction not retired");
    a_jump_dummy: assert property (
        (at_boundary && exec_valid_q && op == OP_JMP) |=>
        (!exec_valid_q && pc_q == $past(target)))
        else $error("jump without dummy cycle");
    a_osc_rc: assert property (
        osc_out_pin_o |-> ($past(rc_s) && phase_q == PH_FETCH && power_q == PW_RUN))
        else $error("phase pin outside fetch");
    a_osc_duty: assert property (
        $rose(osc_out_pin_o) |=> !osc_out_pin_o [*3])
        else $error("phase pin duty wrong");
    a_startup_len: assert property (
        (power_q == PW_START && power_d == PW_RUN) |->
        start_len_q == (CW+1)'(STARTUP_CYCLES - 1))
        else $error("start-up wait length wrong");
    a_acc_add: assert property (
        (at_boundary && exec_valid_q && op == OP_ADD) |=>
        acc_q == 8'($past(acc_q) + $past(rdata)))
        else $error("accumulator add wrong");
    a_skip_dummy: assert property (
        (at_boundary && exec_valid_q && op == OP_SZ && rdata == 8'h00) |=>
        (!exec_valid_q && pc_q == PC_W'($past(pc_q) + 1'b1)))
        else $error("skip did not discard prefetch");
    a_pc_low_page: assert property (
        (at_boundary && exec_valid_q && op == OP_SYS && exec_ir_q[0]) |=>
        (!exec_valid_q && pc_q[7:0] == $past(acc_q) &&
        pc_q[PC_W-1:8] == $past(pc_q[PC_W-1:8])))
        else $error("page branch wrong");
    a_reset_fetch: assert property (
        $rose(reset_n_i) |-> (phase_q == PH_FETCH && pc_q == `PC_RESET))
        else $error("reset did not restart fetch");

    c_jump: cover property (at_boundary && exec_valid_q && op == OP_JMP);
    c_skip: cover property (at_boundary && exec_valid_q && op == OP_SZ && redirect);
    c_wake: cover property (power_q == PW_START ##1 power_q == PW_RUN);
    c_osc: cover property ($rose(osc_out_pin_o));
endmodule

/* tb/prog_rom_model.sv */
// Program memory model that answers the core's instruction fetches
`timescale 1ns/1ps
`include "phase_pipe_params.svh"

module prog_rom_model
    import phase_pipe_pkg::*;
#(
    parameter int PC_W = 10
) (
    // Fetch port
    input  wire logic [PC_W-1:0] addr_i,
    output logic [`IW-1:0] data_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Storage, filled with no-operation words until the bench loads a program
    logic [`IW-1:0] mem [0:(1<<PC_W)-1];

    initial begin
        for (int i = 0; i < (1 << PC_W); i++) begin
            mem[i] = {OP_NOP, 10'h000};
        end
    end

    // Asynchronous read: the word must be there before the edge that ends the fetch phase
    assign data_o = mem[addr_i];
endmodule

/* tb/tb_instruction_phase_pipeline.sv */
// Self-checking bench for the four-phase fetch/execute pipeline
`timescale 1ns/1ps
`include "phase_pipe_params.svh"

module tb_instruction_phase_pipeline
    import phase_pipe_pkg::*;
;
    localparam int PC_W = 10;
    localparam int SU = 8; // Short start-up count keeps the run brief
    localparam int NR = 31;

    typedef struct packed {
        logic [9:0] addr;
        logic [13:0] word;
        logic [7:0] acc;
        logic [3:0] gap; // Cycles since previous retire; 0 unchecked, F never retires
    } row_s;

    logic clk_i;
    logic reset_n_i;
    logic rc_osc_sel_i;
    logic wake_i;
    logic [PC_W-1:0] prog_addr;
    logic [`IW-1:0] prog_data;
    logic osc_pin;
    logic osc_oe;
    phase_flags_s flags;
    logic [7:0] acc;
    logic [PC_W-1:0] pc;
    logic halted;
    logic retire;
    int n_errors = 0;
    int n_compared = 0;
    row_s rows [0:NR-1];
    logic [7:0] exp_acc [$];
    int exp_gap [$];
    int ridx = 0;
    int gap_cnt = 0;
    logic run = 1'b0;
    int n;
    int ph;

    ////////////////////////////////////////////////////////////////////////////////
    // Design and program memory
    instruction_phase_pipeline #(.PC_W(PC_W), .AW(6), .STARTUP_CYCLES(SU))
        instruction_phase_pipeline_inst (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .prog_addr_o(prog_addr),
        .prog_data_i(prog_data), .rc_osc_sel_i(rc_osc_sel_i), .wake_i(wake_i),
        .osc_out_pin_o(osc_pin), .osc_out_oe_o(osc_oe), .phase_flags_o(flags),
        .acc_o(acc), .pc_o(pc), .halted_o(halted), .retire_o(retire));

    prog_rom_model #(.PC_W(PC_W)) prog_rom_model_inst (
        .addr_i(prog_addr), .data_o(prog_data));

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [13:0] mk(input op_e op, input logic [9:0] arg);
        return {op, arg};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic summarize();
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Watchdog sized well beyond the program length plus the wake-up wait
    initial begin
        #(8 * 20000);
        n_errors++;
        summarize();
    end

    // Retire monitor: accumulator value and spacing of each completed instruction
    // Sampled mid-cycle, where the registered outputs have settled
    always @(negedge clk_i) begin
        if (run) begin
            if (retire === 1'b1) begin
                if (ridx < exp_acc.size()) begin
                    check(acc, exp_acc[ridx], "acc at retire");
                    if (exp_gap[ridx] != 0) begin
                        check(gap_cnt, exp_gap[ridx], "retire gap");
                    end
                end
                ridx++;
                gap_cnt = 1;
            end else begin
                gap_cnt++;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset_n_i = 1'b0;
        rc_osc_sel_i = 1'b1;
        wake_i = 1'b0;
        rows = '{
            '{10'h000, mk(OP_LDI, 10'h05A), 8'h5A, 4'h0},
            '{10'h001, mk(OP_MOVM, 10'h001), 8'h5A, 4'h4},
            '{10'h002, mk(OP_LDI, 10'h00F), 8'h0F, 4'h4},
            '{10'h003, mk(OP_AND, 10'h001), 8'h0A, 4'h4},
            '{10'h004, mk(OP_OR, 10'h001), 8'h5A, 4'h4},
            '{10'h005, mk(OP_XOR, 10'h001), 8'h00, 4'h4},
            '{10'h006, mk(OP_ADD, 10'h001), 8'h5A, 4'h4},
            '{10'h007, mk(OP_SUB, 10'h001), 8'h00, 4'h4},
            '{10'h008, mk(OP_INC, 10'h001), 8'h5B, 4'h4},
            '{10'h009, mk(OP_DEC, 10'h001), 8'h59, 4'h4},
            '{10'h00A, mk(OP_RL, 10'h001), 8'hB4, 4'h4},
            '{10'h00B, mk(OP_RR, 10'h001), 8'h2D, 4'h4},
            '{10'h00C, mk(OP_MOVA, 10'h001), 8'h5A, 4'h4},
            '{10'h00D, mk(OP_NOP, 10'h000), 8'h5A, 4'h4},
            '{10'h00E, mk(OP_MOVM, 10'h002), 8'h5A, 4'h4},
            '{10'h00F, mk(OP_LDI, 10'h000), 8'h00, 4'h4},
            '{10'h010, mk(OP_MOVM, 10'h003), 8'h00, 4'h4},
            '{10'h011, mk(OP_SZ, 10'h003), 8'h00, 4'h4},
            '{10'h012, mk(OP_LDI, 10'h0FF), 8'h00, 4'hF},
            '{10'h013, mk(OP_SZ, 10'h002), 8'h00, 4'h8},
            '{10'h014, mk(OP_LDI, 10'h033), 8'h33, 4'h4},
            '{10'h015, mk(OP_JMP, 10'h040), 8'h33, 4'h4},
            '{10'h016, mk(OP_LDI, 10'h0EE), 8'h00, 4'hF},
            '{10'h040, mk(OP_LDI, 10'h030), 8'h30, 4'h8},
            '{10'h041, mk(OP_SYS, 10'h001), 8'h30, 4'h4},
            '{10'h042, mk(OP_LDI, 10'h0EE), 8'h00, 4'hF},
            '{10'h030, mk(OP_LDI, 10'h077), 8'h77, 4'h8},
            '{10'h031, mk(OP_SYS, 10'h000), 8'h77, 4'h4},
            '{10'h032, mk(OP_LDI, 10'h099), 8'h99, 4'h0},
            '{10'h033, mk(OP_SYS, 10'h000), 8'h99, 4'h4},
            '{10'h034, mk(OP_LDI, 10'h0EE), 8'h00, 4'hF}};
        #1;
        // Load the program and the expected retire stream from one table
        for (int i = 0; i < NR; i++) begin
            prog_rom_model_inst.mem[rows[i].addr] = rows[i].word;
            if (rows[i].gap != 4'hF) begin
                exp_acc.push_back(rows[i].acc);
                exp_gap.push_back(int'(rows[i].gap));
            end
        end
        repeat (16) @(posedge clk_i);
        #1;
        check(pc, 10'h000, "pc in reset");
        check(acc, 8'h00, "acc in reset");
        check(flags, 4'h8, "phase in reset");
        check(osc_oe, 1'b0, "pin enable held off in reset");
        reset_n_i = 1'b1;
        run = 1'b1;
        // Phase rotation, pin waveform and fetch address over two instruction cycles
        for (int k = 0; k < 8; k++) begin
            @(negedge clk_i);
            ph = k % 4;
            check(flags, {ph == 0, ph == 3, ph == 2, ph == 1}, "phase");
            // Strap needs two edges through its synchroniser, so the first pulse is missed
            check(osc_pin, ph == 0 && k >= 4, "phase clock pin");
            check(osc_oe, k >= 2, "pin enable with RC option");
            check(pc, k / 4, "pc advance");
            check(prog_addr, k / 4, "fetch address");
        end
        // Program runs into the halt; wait for it under a bound
        n = 0;
        while (halted !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        check(halted, 1'b1, "halted");
        for (int k = 0; k < 8; k++) begin
            @(negedge clk_i);
            check(flags, 4'h8, "phase frozen while halted");
            check(osc_pin, 1'b0, "pin low while halted");
        end
        @(posedge clk_i);
        #1;
        wake_i = 1'b1;
        n = 0;
        while (halted !== 1'b0 && n < 100) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        // Two synchroniser stages and one register edge sit around the start-up count
        check(n >= SU && n <= SU + 4, 1'b1, "start-up length");
        wake_i = 1'b0;
        n = 0;
        while (ridx < exp_acc.size() && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        repeat (16) @(posedge clk_i);
        check(ridx, exp_acc.size(), "retire count");
        #1;
        rc_osc_sel_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        check(osc_oe, 1'b0, "pin released without RC option");
        summarize();
    end
endmodule
